// File: hdl/stm_pkg.sv
package stm_pkg;
    // register map, 8-bit registers on a 3-bit address
    localparam logic [2:0] ADDR_CTRL_A  = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B  = 3'h1;
    localparam logic [2:0] ADDR_CNT_LO  = 3'h2;
    localparam logic [2:0] ADDR_CNT_HI  = 3'h3;
    localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
    localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
    localparam logic [2:0] ADDR_PERIOD  = 3'h6;

    // counter_control_a fields
    localparam int POS_PAUSE   = 7;
    localparam int POS_CKSEL   = 4;
    localparam int POS_ON      = 3;
    localparam logic [7:0] CTRL_A_MASK  = 8'hF8;
    // counter_control_b fields
    localparam int POS_MODE    = 6;
    localparam int POS_PINACT  = 4;
    localparam int POS_OLC     = 3;
    localparam int POS_INVERT  = 2;
    localparam int POS_SWAP    = 1;
    localparam int POS_CLRSRC  = 0;

    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [1:0]  SYS_DIV_LAST = 2'h3;
    localparam logic [5:0]  HDIV16_LAST  = 6'h0F;
    localparam logic [5:0]  HDIV64_LAST  = 6'h3F;

    typedef enum logic [1:0] {
        MODE_CMP   = 2'b00,
        MODE_CAP   = 2'b01,
        MODE_PWM   = 2'b10,
        MODE_TIMER = 2'b11
    } stm_mode_t;

    typedef enum logic [2:0] {
        CK_SYS4   = 3'b000,
        CK_SYS    = 3'b001,
        CK_H16    = 3'b010,
        CK_H64    = 3'b011,
        CK_TBC    = 3'b100,
        CK_H      = 3'b101,
        CK_EXT_R  = 3'b110,
        CK_EXT_F  = 3'b111
    } stm_cksel_t;

    // pin action codes, meaning depends on mode
    localparam logic [1:0] ACT_00 = 2'b00;
    localparam logic [1:0] ACT_01 = 2'b01;
    localparam logic [1:0] ACT_10 = 2'b10;
    localparam logic [1:0] ACT_11 = 2'b11;
endpackage

// File: hdl/stm_timer.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
// What this block does
// [R1] 16-bit up-counter; compare A checks all bits, compare P the upper byte
// [R2] count readable as low and high read-only bytes, zero after reset
// [R3] pause bit 7 holds the count; clearing it resumes from that value
// [R4] 3-bit clock select: sys/4, sys, high/16, high/64, timebase, high, pin edges
// [R5] on/off bit 3 rising clears counter and starts counting
// [R6] on/off low stops counting and keeps the present value
// [R7] compare mode: on/off rising drives pin to the initial output level
// [R8] mode field: compare, capture, PWM/single pulse, timer/counter
// [R9] software should switch the timer off before changing mode
// [R10] timer/counter mode leaves the pin alone; level and invert ignored
// [R11] compare mode A match: keep, drive low, drive high or toggle pin
// [R12] requested level equal to initial level gives no visible change
// [R13] PWM mode actions: force inactive, force active, PWM, single pulse
// [R14] capture on rising, falling, either edge, or disabled
// [R15] software changes PWM pin action only while timer is off
// [R16] output level bit: initial level in compare, active level in PWM
// [R17] invert bit 2 inverts the timer pin output
// [R18] swap bit selects which compare sets PWM period and which duty
// [R19] clear source 1 clears on A match; 0 on P match or overflow
// [R20] overflow clears only with clear source 0 and period compare zero
// [R21] clear source ignored in PWM, single pulse and capture modes
// [R22] period compare matches upper byte: value times 256, zero gives 65536
// [R23] clear source 1 in compare or timer mode raises only the A flag
// [R24] compare mode pin changes only on A match, never on P match
// [R25] external count pin synchronised; one count enable per selected edge
module stm_timer
    import stm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic [7:0]      rdata_o,
    input  wire logic       high_tick_i,
    input  wire logic       tbc_tick_i,
    input  wire logic       ext_count_i,
    input  wire logic       timer_pin_i,
    output logic            timer_pin_o,
    output logic            timer_pin_oe_n_o,
    output logic            compare_a_flag_o,
    output logic            compare_p_flag_o,
    output logic            capture_o
);

    typedef struct packed {
        logic [7:0]  ctla;
        logic [7:0]  ctlb;
        logic [15:0] cmpa;
        logic [7:0]  per;
        logic [15:0] cnt;
        logic        pin;
        logic [1:0]  pre;
        logic [5:0]  hdiv;
        logic [2:0]  xs;
        logic [2:0]  ts;
        logic [7:0]  rdata;
        logic        fa;
        logic        fp;
        logic        cap;
        logic        tp;
        logic        oe_n;
    } stm_state_t;

    stm_state_t st_r;
    stm_state_t st_nxt;

    logic        on;
    logic        pause;
    logic        ccl;
    logic        dpx;
    logic        olc;
    logic        inv;
    logic [1:0]  act;
    logic [2:0]  cksel;
    stm_mode_t   mode;
    logic        cmp_like;
    logic        on_rise;
    logic        tick;
    logic [15:0] inc;
    logic        ma;
    logic        mp;
    logic        ovf;
    logic        clr;
    logic        pwm_act;
    logic        ext_r;
    logic        ext_f;
    logic        tp_r;
    logic        tp_f;

    // field decode of the control registers
    assign on       = st_r.ctla[POS_ON];
    assign pause    = st_r.ctla[POS_PAUSE];
    assign cksel    = st_r.ctla[POS_CKSEL +: 3];
    assign mode     = stm_mode_t'(st_r.ctlb[POS_MODE +: 2]);          // R8
    assign act      = st_r.ctlb[POS_PINACT +: 2];
    assign olc      = st_r.ctlb[POS_OLC];
    assign inv      = st_r.ctlb[POS_INVERT];
    assign dpx      = st_r.ctlb[POS_SWAP];
    assign ccl      = st_r.ctlb[POS_CLRSRC];
    assign cmp_like = (mode == MODE_CMP) || (mode == MODE_TIMER);
    assign on_rise  = wr_i && (addr_i == ADDR_CTRL_A) && wdata_i[POS_ON] && !on; // R5

    // edges of the synchronised pins, read from the second and third stage only
    assign ext_r = st_r.xs[1] && !st_r.xs[2];                           // R25
    assign ext_f = !st_r.xs[1] && st_r.xs[2];                           // R25
    assign tp_r  = st_r.ts[1] && !st_r.ts[2];
    assign tp_f  = !st_r.ts[1] && st_r.ts[2];

    // count clock selection, every source becomes a one-cycle enable
    always_comb begin
        case (stm_cksel_t'(cksel))                                      // R4
            CK_SYS4:  tick = (st_r.pre == SYS_DIV_LAST);
            CK_SYS:   tick = 1'b1;
            CK_H16:   tick = high_tick_i && (st_r.hdiv[3:0] == HDIV16_LAST[3:0]);
            CK_H64:   tick = high_tick_i && (st_r.hdiv == HDIV64_LAST);
            CK_TBC:   tick = tbc_tick_i;
            CK_H:     tick = high_tick_i;
            CK_EXT_R: tick = ext_r;                                     // R25
            CK_EXT_F: tick = ext_f;                                     // R25
            default:  tick = 1'b0;
        endcase
    end

    // comparators look at the value the counter is about to take
    assign inc = st_r.cnt + 16'h0001;
    assign ma  = (inc == st_r.cmpa);                                    // R1
    assign mp  = (st_r.per != RST_BYTE) && (inc[15:8] == st_r.per) && (inc[7:0] == RST_BYTE); // R22
    assign ovf = (st_r.cnt == CNT_MAX);

    // clear source per mode; PWM period follows the swap bit
    always_comb begin
        if (cmp_like) begin
            clr = ccl ? ma : (mp || (ovf && st_r.per == RST_BYTE));     // R19 R20
        end else if (mode == MODE_PWM) begin
            clr = dpx ? ma : (mp || (ovf && st_r.per == RST_BYTE));     // R18 R21
        end else begin
            clr = ovf;                                                  // R21
        end
    end

    // duty compare: zero period byte as duty means always active
    always_comb begin
        if (dpx) begin
            pwm_act = (st_r.per == RST_BYTE) || (st_r.cnt < {st_r.per, RST_BYTE}); // R18 R22
        end else begin
            pwm_act = (st_r.cnt < st_r.cmpa);                           // R18
        end
    end

    // next state of everything
    always_comb begin
        st_nxt       = st_r;
        st_nxt.xs    = {st_r.xs[1:0], ext_count_i};
        st_nxt.ts    = {st_r.ts[1:0], timer_pin_i};
        st_nxt.pre   = st_r.pre + 2'h1;
        st_nxt.hdiv  = high_tick_i ? st_r.hdiv + 6'h01 : st_r.hdiv;
        st_nxt.fa    = 1'b0;
        st_nxt.fp    = 1'b0;
        st_nxt.cap   = 1'b0;
        st_nxt.rdata = RST_BYTE;

        // counting; a stopped or paused counter keeps its value
        if (on && !pause && tick) begin                                 // R3 R6
            st_nxt.cnt = clr ? RST_WORD : inc;                          // R1 R19
            st_nxt.fa  = ma && (mode != MODE_CAP);
            st_nxt.fp  = (mp || (ovf && st_r.per == RST_BYTE)) && !(cmp_like && ccl); // R23
            if (mode == MODE_CMP && ma) begin
                case (act)                                              // R11 R24
                    ACT_01:  st_nxt.pin = 1'b0;
                    ACT_10:  st_nxt.pin = 1'b1;
                    ACT_11:  st_nxt.pin = !st_r.pin;
                    default: st_nxt.pin = st_r.pin;                     // R12
                endcase
            end
            // single pulse ends on compare A; hardware clears the on bit
            if (mode == MODE_PWM && act == ACT_11 && ma) begin          // R13
                st_nxt.ctla[POS_ON] = 1'b0;
            end
        end

        // capture edge per pin action
        if (on && mode == MODE_CAP) begin                               // R14
            case (act)
                ACT_00:  st_nxt.cap = tp_r;
                ACT_01:  st_nxt.cap = tp_f;
                ACT_10:  st_nxt.cap = tp_r || tp_f;
                default: st_nxt.cap = 1'b0;
            endcase
        end

        // register writes; software write wins over the hardware clear of on
        if (wr_i) begin
            case (addr_i)
                ADDR_CTRL_A:  st_nxt.ctla = wdata_i & CTRL_A_MASK;
                ADDR_CTRL_B:  st_nxt.ctlb = wdata_i;
                ADDR_CMPA_LO: st_nxt.cmpa[7:0] = wdata_i;
                ADDR_CMPA_HI: st_nxt.cmpa[15:8] = wdata_i;
                ADDR_PERIOD:  st_nxt.per = wdata_i;
                default:      st_nxt.per = st_r.per;
            endcase
        end
        if (on_rise) begin
            st_nxt.cnt = RST_WORD;                                      // R5
            st_nxt.pin = olc;                                           // R7 R16
        end

        // read data in the cycle after the strobe
        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL_A:  st_nxt.rdata = st_r.ctla;
                ADDR_CTRL_B:  st_nxt.rdata = st_r.ctlb;
                ADDR_CNT_LO:  st_nxt.rdata = st_r.cnt[7:0];             // R2
                ADDR_CNT_HI:  st_nxt.rdata = st_r.cnt[15:8];            // R2
                ADDR_CMPA_LO: st_nxt.rdata = st_r.cmpa[7:0];
                ADDR_CMPA_HI: st_nxt.rdata = st_r.cmpa[15:8];
                ADDR_PERIOD:  st_nxt.rdata = st_r.per;
                default:      st_nxt.rdata = RST_BYTE;
            endcase
        end

        // pin drive by mode
        case (mode)
            MODE_CMP: begin
                st_nxt.oe_n = 1'b0;
                st_nxt.tp   = st_nxt.pin ^ inv;                         // R17 R24
            end
            MODE_PWM: begin
                st_nxt.oe_n = 1'b0;
                case (act)                                              // R13 R16
                    ACT_00:  st_nxt.tp = !olc ^ inv;
                    ACT_01:  st_nxt.tp = olc ^ inv;
                    ACT_10:  st_nxt.tp = (pwm_act ? olc : !olc) ^ inv;  // R17
                    default: st_nxt.tp = ((on && pwm_act) ? olc : !olc) ^ inv;
                endcase
            end
            default: begin
                st_nxt.oe_n = 1'b1;                                     // R10
                st_nxt.tp   = 1'b0;
            end
        endcase
    end

    // single state register; asynchronous reset to constants
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r      <= '0;
            st_r.oe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o          = st_r.rdata;
    assign timer_pin_o      = st_r.tp;
    assign timer_pin_oe_n_o = st_r.oe_n;
    assign compare_a_flag_o = st_r.fa;
    assign compare_p_flag_o = st_r.fp;
    assign capture_o        = st_r.cap;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_count_up_step: assert property (                                  // R1
        (on && !pause && tick && !clr && !on_rise) |=> (st_r.cnt == $past(inc)))
        else $error("counter did not step by one");
    a_read_count_low: assert property (                                 // R2
        (rd_i && addr_i == ADDR_CNT_LO) |=> (rdata_o == $past(st_r.cnt[7:0])))
        else $error("count low byte read wrong");
    a_pause_holds_count: assert property (                              // R3
        (on && pause && !wr_i) |=> $stable(st_r.cnt))
        else $error("paused counter moved");
    a_on_rise_clears: assert property (                                 // R5
        on_rise |=> (st_r.cnt == RST_WORD) && on)
        else $error("on rise did not clear counter");
    a_off_holds_count: assert property (                                // R6
        (!on && !on_rise) |=> $stable(st_r.cnt))
        else $error("stopped counter moved");
    a_init_pin_level: assert property (                                 // R7
        (on_rise && mode == MODE_CMP) |=> (timer_pin_o == $past(olc ^ inv)))
        else $error("initial pin level wrong");
    a_timer_pin_free: assert property (                                 // R10
        (mode == MODE_TIMER) |=> timer_pin_oe_n_o)
        else $error("timer mode drives pin");
    a_clear_on_a: assert property (                                     // R19
        (on && !pause && tick && cmp_like && ccl && ma && !on_rise) |=> (st_r.cnt == RST_WORD) ##0 compare_a_flag_o)
        else $error("A match did not clear counter");
    a_no_p_flag: assert property (                                      // R23
        (cmp_like && ccl) |=> !compare_p_flag_o)
        else $error("P flag raised with clear source A");
    a_ext_edge_count: assert property (                                 // R25
        (cksel == CK_EXT_R && on && !pause && !ext_r && !on_rise) |=> $stable(st_r.cnt))
        else $error("count without external edge");

endmodule

// File: dv/stm_tb.sv
`timescale 1ns/100ps
module testbench
    import stm_pkg::*;
;
    logic       clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, high_tick_i = 1;
    logic       tbc_tick_i = 0, ext_count_i = 0, timer_pin_i = 0;
    logic [2:0] addr_i = 0, div = 0;
    logic [7:0] wdata_i = 0, rdata_o, d;
    logic       timer_pin_o, timer_pin_oe_n_o, compare_a_flag_o, compare_p_flag_o, capture_o;
    logic [15:0] v, v2, e;
    int          num_errors = 0, check_count = 0, na, np, nc, h, i, m;
    int          lo_t[8] = '{13, 59, 2, 0, 28, 59, 6, 6};
    int          hi_t[8] = '{18, 65, 6, 2, 34, 65, 10, 10};
    // last entry is single pulse: high from on rise until the A match at 0x0040
    logic [7:0]  pb[7] = '{8'hA8, 8'hA0, 8'hAA, 8'h88, 8'h98, 8'h9C, 8'hB8};
    logic [7:0]  pa[7] = '{8'h40, 8'h40, 8'hC8, 8'h40, 8'h40, 8'h40, 8'h40};
    int          plo[7] = '{125, 381, 508, 0, 512, 0, 58};
    int          phi[7] = '{131, 387, 512, 0, 512, 0, 62};

    stm_timer i_stm_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .high_tick_i(high_tick_i), .tbc_tick_i(tbc_tick_i),
        .ext_count_i(ext_count_i), .timer_pin_i(timer_pin_i), .timer_pin_o(timer_pin_o),
        .timer_pin_oe_n_o(timer_pin_oe_n_o), .compare_a_flag_o(compare_a_flag_o),
        .compare_p_flag_o(compare_p_flag_o), .capture_o(capture_o));

    // 50 ns system clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // tick sources: timebase every other cycle, external pin edge every 4 cycles
    always @(posedge clk_i) begin
        tbc_tick_i <= ~tbc_tick_i;
        div <= div + 3'h1;
        if (div[1:0] == 2'h3) ext_count_i <= ~ext_count_i;
        if (compare_a_flag_o === 1'b1) na++;
        if (compare_p_flag_o === 1'b1) np++;
        if (capture_o === 1'b1) nc++;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] x);
        @(posedge clk_i);
        addr_i <= a; wdata_i <= x; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] x);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 x = rdata_o;
    endtask

    task automatic getcnt(output logic [15:0] c);
        rd(ADDR_CNT_LO, c[7:0]);
        rd(ADDR_CNT_HI, c[15:8]);
    endtask

    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
        check_count++;
        if (g !== ex) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, ex, g);
        end
    endtask

    // range compare, since tick phase against the bus write is not fixed
    task automatic chkr(input string nm, input int lo, input int hi, input logic [15:0] g);
        check_count++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            num_errors++;
            $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // watchdog, about three times the expected run
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // reset values, then 0xF7 pattern: counts and hole stay zero
        for (i = 0; i < 8; i++) begin rd(i[2:0], d); chk("reset", 0, d); end
        for (i = 0; i < 8; i++) wr(i[2:0], 8'hF7);
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], d);
            e = (i == 0) ? 16'h00F0 : (i == 2 || i == 3 || i == 7) ? 16'h0000 : 16'h00F7;
            chk("readback", e, d);
        end
        $display("test registers done");
        // every clock source, in timer mode with pin level bits set
        wr(ADDR_CTRL_B, 8'hCC);
        for (i = 0; i < 8; i++) begin
            wr(ADDR_CTRL_A, 8'(i << 4));
            wr(ADDR_CTRL_A, 8'(i << 4) | 8'h88);
            getcnt(v); chk("count after on", 0, v);
            wr(ADDR_CTRL_A, 8'(i << 4) | 8'h08);
            repeat (60) @(posedge clk_i);
            wr(ADDR_CTRL_A, 8'(i << 4) | 8'h88);
            getcnt(v); chkr("ticks", lo_t[i], hi_t[i], v);
            repeat (10) @(posedge clk_i);
            getcnt(v2); chk("paused", v, v2);
            chk("timer mode pin released", 1, timer_pin_oe_n_o);
            wr(ADDR_CTRL_A, 8'(i << 4));
            getcnt(v2); chk("off", v, v2);
        end
        $display("test clocks done");
        // compare mode: every action, level and invert; A at 0x0120, P at 0x0100
        wr(ADDR_CMPA_LO, 8'h20); wr(ADDR_CMPA_HI, 8'h01); wr(ADDR_PERIOD, 8'h01);
        for (m = 0; m < 16; m++) begin
            wr(ADDR_CTRL_A, 8'h00);
            wr(ADDR_CTRL_B, {4'h0, m[1:0], m[2], m[3]} << 2 | 8'h01);
            wr(ADDR_CTRL_A, 8'h98);
            repeat (2) @(posedge clk_i);
            chk("initial pin", m[2] ^ m[3], timer_pin_o);
            chk("pin driven", 0, timer_pin_oe_n_o);
            na = 0; np = 0;
            wr(ADDR_CTRL_A, 8'h18);
            for (i = 0; i < 400 && na == 0; i++) @(posedge clk_i);
            repeat (2) @(posedge clk_i);
            e = (m[1:0] == 0) ? m[2] : (m[1:0] == 1) ? 0 : (m[1:0] == 2) ? 1 : !m[2];
            chk("pin after A match", e[0] ^ m[3], timer_pin_o);
            chk("no P flag", 0, np);
        end
        // clear on P: A at 0x0120 is never reached, P clears every 256 ticks
        wr(ADDR_CTRL_A, 8'h00); wr(ADDR_CTRL_B, 8'h30);
        wr(ADDR_CTRL_A, 8'h98); na = 0; np = 0;
        wr(ADDR_CTRL_A, 8'h18);
        repeat (600) @(posedge clk_i);
        chk("P flags", 2, np);
        chk("A flags", 0, na);
        chk("pin untouched by P", 0, timer_pin_o);
        $display("test compare done");
        // PWM: period 256 from P, duty from A, then swapped and forced levels
        for (m = 0; m < 7; m++) begin
            wr(ADDR_CTRL_A, 8'h00);
            wr(ADDR_CTRL_B, pb[m] | 8'h01);
            wr(ADDR_CMPA_LO, pa[m]); wr(ADDR_CMPA_HI, 8'h00);
            wr(ADDR_CTRL_A, 8'h18);
            repeat (4) @(posedge clk_i);
            h = 0;
            repeat (512) begin @(posedge clk_i); #1 if (timer_pin_o === 1'b1) h++; end
            chkr("pwm high cycles", plo[m], phi[m], h);
        end
        $display("test pwm done");
        // capture: rising, falling, both, disabled
        for (m = 0; m < 4; m++) begin
            wr(ADDR_CTRL_A, 8'h00);
            wr(ADDR_CTRL_B, 8'h40 | 8'(m << 4));
            wr(ADDR_CTRL_A, 8'h18);
            nc = 0;
            timer_pin_i <= 1'b1; repeat (8) @(posedge clk_i);
            timer_pin_i <= 1'b0; repeat (8) @(posedge clk_i);
            chk("captures", (m == 2) ? 2 : (m == 3) ? 0 : 1, nc);
            chk("capture pin released", 1, timer_pin_oe_n_o);
        end
        $display("test capture done");
        wrap_up();
    end
endmodule
